// file: src/cpf_pair_ctrl.sv
// Operation
// - Channels form pairs n, n+1; this block serves pairs 6 and 4.
// - Armed pair 6 captures the counter on its channel input events.
// - Arm works only with extended features and dual capture enabled.
// - One-shot mode clears the arm once the n+1 capture is made.
// - Dual capture enable switches both channels to capture mode only while extended features are enabled.
// - Protected bits accept writes only while protection is disabled.
// - With combine set, complement drives channel n+1 inverse of n, else equal to n.
// - Combine bit selects independent or combined pair operation.
// - Bit 23 reads zero and ignores writes.
// - Pair 4 fault control enable bit gates fault logic for the pair.
// - Pair 4 sync enable bit gates compare value synchronisation.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpf_pair_ctrl
  import cpf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [CNT_W-1:0] i_counter,
  input wire logic i_ch6_in,
  input wire logic i_ch7_in,
  input wire logic i_ch6_pwm,
  input wire logic i_ch7_pwm,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_ch6_out,
  output logic o_ch7_out,
  output logic o_pair6_combine,
  output logic o_dual_capture_mode,
  output logic o_pair4_fault_en,
  output logic o_pair4_sync_en
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic arm_ff;
  logic den_ff;
  logic comp_ff;
  logic comb_ff;
  logic flt_ff;
  logic sync_ff;
  logic ext_ff;
  logic wpd_ff;
  logic cont_ff;
  logic [1:0] els_n_ff;
  logic [1:0] els_n1_ff;
  logic done_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic ch6_ff;
  logic ch7_ff;
  logic mode_ff;
  logic nxt_arm;
  logic nxt_done;
  logic [DATA_W-1:0] nxt_rdata;

  logic acc;
  logic wr;
  logic wr_comb;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_stat;
  logic mapped;
  logic mode_eff;
  logic cap_active;
  logic [1:0] sel_n;
  logic [1:0] sel_n1;
  logic hit_n;
  logic hit_n1;
  logic cap_done;
  logic cap_busy;
  logic [CNT_W-1:0] cap_n;
  logic [CNT_W-1:0] cap_n1;
  logic [DATA_W-1:0] comb_rd;

  // ---------------------------------------------------------------
  // APB slave: one wait state, completion at pready
  // ---------------------------------------------------------------
  assign acc = i_psel & i_penable & pready_ff;
  assign wr = acc & i_pwrite;

  assign wr_comb = wr & (i_paddr == OFF_COMBINE);
  assign wr_ctrl = wr & (i_paddr == OFF_CTRL);
  assign wr_cfg = wr & (i_paddr == OFF_CAPCFG);
  assign wr_stat = wr & (i_paddr == OFF_STATUS);

  // Pair control read image; bit 23 and unused bits stay low
  always_comb begin
    comb_rd = RD_ZERO;
    comb_rd[B_ARM] = arm_ff;
    comb_rd[B_DEN] = den_ff;
    comb_rd[B_COMP] = comp_ff;
    comb_rd[B_COMB] = comb_ff;
    comb_rd[B_FLT] = flt_ff;
    comb_rd[B_SYNC] = sync_ff;
    comb_rd[B_RSV] = 1'b0;
  end

  // Read mux and address decode; unmapped places read zero
  always_comb begin
    nxt_rdata = RD_ZERO;
    mapped = 1'b1;
    if (i_paddr == OFF_COMBINE) begin
      nxt_rdata = comb_rd;
    end else if (i_paddr == OFF_CTRL) begin
      nxt_rdata[B_EXT] = ext_ff;
      nxt_rdata[B_WPD] = wpd_ff;
    end else if (i_paddr == OFF_CAPCFG) begin
      nxt_rdata[B_CONT] = cont_ff;
      nxt_rdata[B_ELS_N +: 2] = els_n_ff;
      nxt_rdata[B_ELS_N1 +: 2] = els_n1_ff;
    end else if (i_paddr == OFF_CAP_N) begin
      nxt_rdata[CNT_W-1:0] = cap_n;
    end else if (i_paddr == OFF_CAP_N1) begin
      nxt_rdata[CNT_W-1:0] = cap_n1;
    end else if (i_paddr == OFF_STATUS) begin
      nxt_rdata[B_DONE] = done_ff;
      nxt_rdata[B_BUSY] = cap_busy;
    end else begin
      mapped = 1'b0;
    end
  end

  // Handshake and answer flops
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_ff <= RST_BIT;
      pslverr_ff <= RST_BIT;
      prdata_ff <= RD_ZERO;
    end else begin
      pready_ff <= i_psel & i_penable & ~pready_ff;
      if (i_psel && i_penable && !pready_ff) begin
        pslverr_ff <= ~mapped;
        prdata_ff <= i_pwrite ? RD_ZERO : nxt_rdata;
      end else begin
        pslverr_ff <= RST_BIT;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register: feature enable and write protect disable
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_ff <= RST_BIT;
      wpd_ff <= RST_BIT;
    end else if (wr_ctrl) begin
      ext_ff <= i_pwdata[B_EXT];
      wpd_ff <= i_pwdata[B_WPD];
    end
  end

  // Capture configuration, meaningful only in dual capture mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cont_ff <= RST_BIT;
      els_n_ff <= RST_ELS;
      els_n1_ff <= RST_ELS;
    end else if (wr_cfg) begin
      cont_ff <= i_pwdata[B_CONT];
      els_n_ff <= i_pwdata[B_ELS_N +: 2];
      els_n1_ff <= i_pwdata[B_ELS_N1 +: 2];
    end
  end

  // ---------------------------------------------------------------
  // Pair control bits
  // ---------------------------------------------------------------
  // Protected bits: a blocked write leaves them alone
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      den_ff <= RST_BIT;
      comp_ff <= RST_BIT;
      comb_ff <= RST_BIT;
      flt_ff <= RST_BIT;
    end else if (wr_comb && wpd_ff) begin
      den_ff <= i_pwdata[B_DEN];
      comp_ff <= i_pwdata[B_COMP];
      comb_ff <= i_pwdata[B_COMB];
      flt_ff <= i_pwdata[B_FLT];
    end
  end

  // Unprotected sync enable updates regardless of protection
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_ff <= RST_BIT;
    end else if (wr_comb) begin
      sync_ff <= i_pwdata[B_SYNC];
    end
  end

  // Arm: a software write of one beats the one-shot clear
  always_comb begin
    nxt_arm = arm_ff;
    if (cap_done && !cont_ff) begin
      nxt_arm = 1'b0;
    end
    if (wr_comb) begin
      nxt_arm = i_pwdata[B_ARM] | (arm_ff & ~(cap_done & ~cont_ff));
      if (!i_pwdata[B_ARM]) nxt_arm = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arm_ff <= RST_BIT;
    end else begin
      arm_ff <= nxt_arm;
    end
  end

  // ---------------------------------------------------------------
  // Dual edge capture on pair 6
  // ---------------------------------------------------------------
  assign mode_eff = ext_ff & den_ff;
  assign cap_active = mode_eff & arm_ff;
  // Edge selects take the capture meaning only in this mode
  assign sel_n = mode_eff ? els_n_ff : EDGE_NONE;
  assign sel_n1 = mode_eff ? els_n1_ff : EDGE_NONE;

  cpf_edge_det u_edge_n (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_sig(i_ch6_in),
    .i_sel(sel_n),
    .o_hit(hit_n)
  );

  // Second edge is taken from channel n+1's own input
  cpf_edge_det u_edge_n1 (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_sig(i_ch7_in),
    .i_sel(sel_n1),
    .o_hit(hit_n1)
  );

  cpf_dual_capture u_cap (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_active(cap_active),
    .i_hit_n(hit_n),
    .i_hit_n1(hit_n1),
    .i_counter(i_counter),
    .o_cap_n(cap_n),
    .o_cap_n1(cap_n1),
    .o_done(cap_done),
    .o_busy(cap_busy)
  );

  // Sticky pair-done flag, write one to clear, set wins
  always_comb begin
    nxt_done = done_ff;
    if (wr_stat && i_pwdata[B_DONE]) nxt_done = 1'b0;
    if (cap_done) nxt_done = 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_ff <= RST_BIT;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ---------------------------------------------------------------
  // Pair outputs, registered
  // ---------------------------------------------------------------
  // Channel 7 follows channel 6 only while combined
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ch6_ff <= RST_BIT;
      ch7_ff <= RST_BIT;
    end else begin
      ch6_ff <= i_ch6_pwm;
      if (comb_ff) begin
        ch7_ff <= comp_ff ? ~i_ch6_pwm : i_ch6_pwm;
      end else begin
        ch7_ff <= i_ch7_pwm;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ff <= RST_BIT;
    end else begin
      mode_ff <= mode_eff;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_ch6_out = ch6_ff;
  assign o_ch7_out = ch7_ff;
  assign o_pair6_combine = comb_ff;
  assign o_dual_capture_mode = mode_ff;
  assign o_pair4_fault_en = flt_ff;
  assign o_pair4_sync_en = sync_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_rsvd_reads_zero: assert property (
    i_psel && i_penable && !pready_ff && !i_pwrite &&
    i_paddr == OFF_COMBINE |=> o_pready && !o_prdata[B_RSV])
    else $error("reserved bit read back nonzero");

  a_wp_blocks_write: assert property (
    wr_comb && !wpd_ff |=> $stable({den_ff, comp_ff, comb_ff, flt_ff}))
    else $error("protected bit changed while protected");
  a_unprot_still_wr: assert property (
    wr_comb && !wpd_ff |=> o_pair4_sync_en == $past(i_pwdata[B_SYNC]))
    else $error("sync enable lost under protection");
  a_fault_en_wr: assert property (
    wr_comb && wpd_ff |=> o_pair4_fault_en == $past(i_pwdata[B_FLT]))
    else $error("fault enable not written");
  a_sync_en_wr: assert property (
    wr_comb ##1 !wr_comb [*2] |->
    o_pair4_sync_en == $past(i_pwdata[B_SYNC], 2))
    else $error("sync enable not held");

  a_comp_inverts: assert property (
    comb_ff && comp_ff |=> o_ch7_out == !$past(i_ch6_pwm))
    else $error("complement output wrong");
  a_comp_follows: assert property (
    comb_ff && !comp_ff |=> o_ch7_out == $past(i_ch6_pwm))
    else $error("channel 7 not equal to channel 6");
  a_indep_pair: assert property (
    !comb_ff |=> o_ch7_out == $past(i_ch7_pwm))
    else $error("independent channel 7 wrong");

  a_arm_gated: assert property (
    !(ext_ff && den_ff && arm_ff) |=>
    $stable({cap_n, cap_n1}) && !cap_busy)
    else $error("capture ran without mode enable");
  a_oneshot_clear: assert property (
    cap_done && !cont_ff && !wr_comb |=> !arm_ff)
    else $error("one-shot arm not cleared");
  a_capture_value: assert property (
    cap_done |=> cap_n1 == $past(i_counter) && done_ff)
    else $error("capture value wrong");
  a_mode_flag: assert property (
    ##1 o_dual_capture_mode == $past(ext_ff && den_ff))
    else $error("mode flag wrong");

  c_oneshot_pair: cover property (cap_done && !cont_ff);
  c_cont_pair: cover property (cap_done && cont_ff ##[1:50] cap_done);
  c_blocked_wr: cover property (wr_comb && !wpd_ff);
  c_comp_mode: cover property (comb_ff && comp_ff);
endmodule
`default_nettype wire

// file: src/cpf_pkg.sv
package cpf_pkg;
  // ---------------------------------------------------------------
  // Bus and data widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_COMBINE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CAPCFG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CAP_N = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CAP_N1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

  // ---------------------------------------------------------------
  // Pair control register fields
  // ---------------------------------------------------------------
  localparam int B_ARM = 27;
  localparam int B_DEN = 26;
  localparam int B_COMP = 25;
  localparam int B_COMB = 24;
  localparam int B_RSV = 23;
  localparam int B_FLT = 22;
  localparam int B_SYNC = 21;

  // Control, capture config and status fields
  localparam int B_EXT = 0;
  localparam int B_WPD = 1;
  localparam int B_CONT = 0;
  localparam int B_ELS_N = 1;
  localparam int B_ELS_N1 = 3;
  localparam int B_DONE = 0;
  localparam int B_BUSY = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_BIT = 1'b0;
  localparam logic [1:0] RST_ELS = 2'h0;
  localparam logic [CNT_W-1:0] RST_CAP = 16'h0000;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // Edge select encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_WAIT_N,
    CAP_WAIT_N1
  } cpf_cap_state_t;

  // Edge hit for a given select code
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction
endpackage

// file: src/cpf_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module cpf_edge_det
  import cpf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_sig,
  input wire logic [1:0] i_sel,
  output logic o_hit
);
  logic prev_ff;

  // ---------------------------------------------------------------
  // Previous sample
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_ff <= RST_BIT;
    end else begin
      prev_ff <= i_sig;
    end
  end

  // Selected edge, same cycle as the new level
  assign o_hit = edge_hit(i_sel, prev_ff, i_sig);
endmodule
`default_nettype wire

// file: src/cpf_dual_capture.sv
`timescale 1ns/1ps
`default_nettype none
module cpf_dual_capture
  import cpf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_active,
  input wire logic i_hit_n,
  input wire logic i_hit_n1,
  input wire logic [CNT_W-1:0] i_counter,
  output logic [CNT_W-1:0] o_cap_n,
  output logic [CNT_W-1:0] o_cap_n1,
  output logic o_done,
  output logic o_busy
);
  cpf_cap_state_t state_ff;
  cpf_cap_state_t nxt_state;
  logic [CNT_W-1:0] cap_n_ff;
  logic [CNT_W-1:0] cap_n1_ff;

  // ---------------------------------------------------------------
  // Sequence: first edge on n, then edge on n+1
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CAP_IDLE: nxt_state = i_active ? CAP_WAIT_N : CAP_IDLE;
      CAP_WAIT_N: if (i_hit_n) nxt_state = CAP_WAIT_N1;
      CAP_WAIT_N1: if (i_hit_n1) nxt_state = CAP_IDLE;
      default: nxt_state = CAP_IDLE;
    endcase
    // Dropping the arm abandons a half-done pair
    if (!i_active) nxt_state = CAP_IDLE;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= CAP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Counter snapshots
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap_n_ff <= RST_CAP;
      cap_n1_ff <= RST_CAP;
    end else begin
      if (i_active && state_ff == CAP_WAIT_N && i_hit_n) begin
        cap_n_ff <= i_counter;
      end
      if (o_done) begin
        cap_n1_ff <= i_counter;
      end
    end
  end

  assign o_done = i_active && state_ff == CAP_WAIT_N1 && i_hit_n1;
  assign o_busy = state_ff != CAP_IDLE;
  assign o_cap_n = cap_n_ff;
  assign o_cap_n1 = cap_n1_ff;
endmodule
`default_nettype wire

// file: sim/channel_pair_function_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module channel_pair_function_control_bench
  import cpf_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [CNT_W-1:0] counter = '0;
  logic ch6_in = 1'b0, ch7_in = 1'b0, ch6_pwm = 1'b0, ch7_pwm = 1'b0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, ch6_out, ch7_out;
  logic comb, dual_mode, flt_en, sync_en;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // Clock, reset and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // Whole run is well under this; a stuck handshake lands here
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  cpf_pair_ctrl u_dut (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_counter(counter),
    .i_ch6_in(ch6_in), .i_ch7_in(ch7_in),
    .i_ch6_pwm(ch6_pwm), .i_ch7_pwm(ch7_pwm),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_ch6_out(ch6_out), .o_ch7_out(ch7_out),
    .o_pair6_combine(comb), .o_dual_capture_mode(dual_mode),
    .o_pair4_fault_en(flt_en), .o_pair4_sync_en(sync_en)
  );

  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Request held until pready is seen at an edge; no wait count assumed
  task automatic apb(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    @(posedge i_ref_clk);
    while (pready !== 1'b1) @(posedge i_ref_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk1(e, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk32(r, exp);
    chk1(e, 1'b0);
  endtask

  // Rise on channel 6 then fall on channel 7, counter held around each
  task automatic capture_pair(input logic [15:0] cn, input logic [15:0] cn1);
    ch6_in <= 1'b0;
    ch7_in <= 1'b1;
    tick(4);
    counter <= cn;
    ch6_in <= 1'b1;
    tick(4);
    counter <= cn1;
    ch7_in <= 1'b0;
    tick(4);
  endtask

  task automatic summarize();
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    logic [31:0] d;
    tick(10);
    i_arst_n <= 1'b1;
    // Every register clears on reset
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4), 32'h0000_0000);
    end
    // Unmapped place: error, no data
    apb(1'b1, 8'h18, 32'hffff_ffff, r, e);
    chk1(e, 1'b1);
    apb(1'b0, 8'h18, 32'h0000_0000, r, e);
    chk32(r, 32'h0000_0000);
    chk1(e, 1'b1);
    // Protection active: only arm and sync take the write
    wr(OFF_COMBINE, 32'hffff_ffff);
    rd(OFF_COMBINE, 32'h0820_0000);
    chk1(comb, 1'b0);
    chk1(flt_en, 1'b0);
    chk1(sync_en, 1'b1);
    // Protection off, feature still off: mode output stays low
    wr(OFF_CTRL, 32'h0000_0002);
    rd(OFF_CTRL, 32'h0000_0002);
    wr(OFF_COMBINE, 32'hffff_ffff);
    rd(OFF_COMBINE, 32'h0f60_0000);
    chk1(comb, 1'b1);
    chk1(flt_en, 1'b1);
    chk1(dual_mode, 1'b0);
    wr(OFF_CTRL, 32'h0000_0003);
    tick(2);
    chk1(dual_mode, 1'b1);
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_COMBINE, 32'h0000_0000);
    tick(2);
    chk1(flt_en, 1'b0);
    chk1(sync_en, 1'b0);
    chk1(dual_mode, 1'b0);
    // Output pairing over combine, complement and both pwm inputs
    for (int i = 0; i < 16; i++) begin
      d = 32'h0000_0000;
      d[B_COMB] = i[2];
      d[B_COMP] = i[1];
      wr(OFF_COMBINE, d);
      ch6_pwm <= i[0];
      ch7_pwm <= i[3];
      tick(3);
      chk1(ch6_out, i[0]);
      chk1(ch7_out, i[2] ? (i[0] ^ i[1]) : i[3]);
      chk1(comb, i[2]);
    end
    // Armed with feature off: nothing is captured
    wr(OFF_COMBINE, 32'h0000_0000);
    wr(OFF_CAPCFG, 32'h0000_0012);
    wr(OFF_COMBINE, 32'h0c00_0000);
    capture_pair(16'h1111, 16'h2222);
    rd(OFF_CAP_N, 32'h0000_0000);
    rd(OFF_CAP_N1, 32'h0000_0000);
    // One-shot capture, arm cleared by hardware afterwards
    wr(OFF_CTRL, 32'h0000_0003);
    tick(2);
    capture_pair(16'h1234, 16'h5678);
    rd(OFF_CAP_N, 32'h0000_1234);
    rd(OFF_CAP_N1, 32'h0000_5678);
    rd(OFF_STATUS, 32'h0000_0001);
    rd(OFF_COMBINE, 32'h0400_0000);
    wr(OFF_STATUS, 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0000);
    // Continuous capture keeps the arm set
    wr(OFF_CAPCFG, 32'h0000_0013);
    wr(OFF_COMBINE, 32'h0c00_0000);
    tick(2);
    capture_pair(16'h2345, 16'h6789);
    rd(OFF_CAP_N, 32'h0000_2345);
    rd(OFF_CAP_N1, 32'h0000_6789);
    rd(OFF_COMBINE, 32'h0c00_0000);
    // Dual capture enable protected again once protection returns
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_COMBINE, 32'h0000_0000);
    rd(OFF_COMBINE, 32'h0400_0000);
    summarize();
  end
endmodule
`default_nettype wire
